// *** timer_pwm_capture_ir_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_capture_ir_bench;
   logic        mclk, rst_n, wide_en, ir_mode, ir_out;
   logic [7:0]  wide_presc;
   logic [15:0] wide_period, narrow_presc, narrow_period, narrow_cmp;
   logic [15:0] wide_count;
   logic [79:0] wide_cmp, cap_value;
   logic [4:0]  ch_capture, cap_in, wide_pwm, cap_event;
   logic [1:0]  narrow_en, narrow_pwm;
   int          n_mismatch, compares, hw[5], hn[2], hi, cmax;
   tpci_pin_model pin_inst (.mclk(mclk), .cap_in(cap_in));
   tpci_timers tpci_timers_inst (.mclk(mclk), .rst_n(rst_n),
      .wide_en(wide_en), .ir_mode(ir_mode), .wide_presc(wide_presc),
      .wide_period(wide_period), .wide_cmp(wide_cmp),
      .ch_capture(ch_capture), .cap_in(cap_in), .narrow_en(narrow_en),
      .narrow_presc(narrow_presc), .narrow_period(narrow_period),
      .narrow_cmp(narrow_cmp), .wide_pwm(wide_pwm),
      .cap_value(cap_value), .cap_event(cap_event),
      .narrow_pwm(narrow_pwm), .ir_out(ir_out), .wide_count(wide_count));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (exp !== got) begin
         n_mismatch++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // high cycles of every pwm output and of ir_out over n clocks, plus the top count
   task automatic meas(input int n);
      hw = '{0, 0, 0, 0, 0};
      hn = '{0, 0};
      hi = 0;
      cmax = 0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         for (int c = 0; c < 5; c++) hw[c] += (wide_pwm[c] === 1'b1);
         for (int c = 0; c < 2; c++) hn[c] += (narrow_pwm[c] === 1'b1);
         hi += (ir_out === 1'b1);
         if (wide_count > cmax) cmax = wide_count;
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   // wide presc 2 period 9: 30 clocks a cycle, high 3*cmp of them
   task automatic t_pwm();
      wide_en = 1'b1;
      narrow_en = 2'h3;
      meas(120);
      meas(120);
      for (int c = 0; c < 5; c++)
         chk("wide pwm", 12 * wide_cmp[16*c+:16], hw[c]);
      chk("wide top", 16'h0009, cmax);
      chk("narrow pwm 0", 60, hn[0]);
      chk("narrow pwm 1", 120, hn[1]);
      chk("ir off", 0, hi);
   endtask
   // wide steps per 8-clock narrow period; ir = both pwms
   task automatic t_ir();
      #1;
      ir_mode = 1'b1;
      wide_period = 16'h0004;
      wide_cmp[15:0] = 16'h0002;
      meas(80);
      meas(120);
      chk("ir high", 24, hi);
      chk("ir wide top", 16'h0004, cmax);
      #1;
      ir_mode = 1'b0;
   endtask
   task automatic t_capture();
      logic [15:0] v[$];
      int          bad;
      bad = 0;
      wide_presc = 8'h00;
      wide_period = 16'hFFFF;
      wide_cmp[47:32] = 16'hFFFF;
      ch_capture = 5'h04;
      fork
         pin_inst.pulse(2, 3);
         repeat (20) begin
            @(posedge mclk);
            #1;
            if (cap_event[2] === 1'b1) v.push_back(cap_value[47:32]);
            if (wide_pwm[2] !== 1'b0) bad++;
         end
      join
      chk("capture events", 2, v.size());
      if (v.size() == 2) chk("capture span", 3, v[1] - v[0]);
      chk("pwm in capture", 0, bad);
   endtask
   task automatic t_off();
      #1;
      wide_en = 1'b0;
      narrow_en = 2'h0;
      meas(20);
      meas(40);
      chk("off count", 0, cmax);
      chk("off pwm", 0, hw[0] + hw[1] + hw[2] + hw[3] + hw[4] + hn[0] + hn[1]);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      {wide_en, ir_mode, narrow_en, ch_capture} = '0;
      wide_presc = 8'h02;
      wide_period = 16'h0009;
      wide_cmp = {16'h000A, 16'h0009, 16'h0005, 16'h0001, 16'h0000};
      narrow_presc = {8'h00, 8'h01};
      narrow_period = {8'h04, 8'h03};
      narrow_cmp = {8'h05, 8'h02};
      repeat (10) @(posedge mclk);
      #2;
      chk("reset outs", 0, {wide_pwm, cap_event, narrow_pwm, ir_out});
      rst_n = 1'b1;
      t_pwm();
      t_ir();
      t_capture();
      t_off();
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      end_sim();
   end
endmodule // timer_pwm_capture_ir_bench
`default_nettype wire

// *** tpci_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// outside source on the capture pins
module tpci_pin_model (
   // clock
   input  wire logic       mclk,
   // capture pins
   output var  logic [4:0] cap_in
);
   initial cap_in = 5'h00;
   // ==========================================================
   // pulse
   // shorter pulses would slip through the synchronisers
   task automatic pulse(input int ch, input int width);
      if (width < 2) width = 2;
      @(posedge mclk);
      #2;
      cap_in[ch] = 1'b1;
      repeat (width) @(posedge mclk);
      #2;
      cap_in[ch] = 1'b0;
   endtask
endmodule // tpci_pin_model
`default_nettype wire

// *** tpci_pkg.sv ***
package tpci_pkg;
   // ======================================================================
   // widths
   localparam int WIDE_W     = 16;
   localparam int NARROW_W   = 8;
   localparam int NUM_CH     = 5;
   localparam int PRESC_W    = 8;
   // ======================================================================
   // reset values
   localparam logic [15:0] WIDE_PERIOD_RST   = 16'hFFFF;
   localparam logic [7:0]  NARROW_PERIOD_RST = 8'hFF;
   localparam logic [7:0]  PRESC_RST         = 8'h00;
   // ======================================================================
   // timing: capture pulse least width, tenths of a clock period
   localparam int CAP_MIN_TENTHS = 15;
   localparam int SYNC_STAGES    = 3;
endpackage : tpci_pkg

// *** tpci_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// prescaler and period counter, one instance per timer; the wide timer uses the hold path instead in ir mode
module tpci_tick #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst_n,
   // control
   input  wire logic               enable,
   input  wire logic [7:0]         presc,
   input  wire logic [W-1:0]       period,
   // state
   output logic      [W-1:0]       count,
   output logic                    wrap
);
   logic [7:0]   div;
   logic [7:0]   next_div;
   logic [W-1:0] next_count;
   logic         next_wrap;
   logic         tick;

   always_comb begin
      next_div   = div;
      next_count = count;
      next_wrap  = 1'b0;
      tick       = 1'b0;
      if (enable) begin
         if (div >= presc) begin
            next_div = 8'h00;
            tick     = 1'b1;
         end else begin
            next_div = div + 8'h01;
         end
      end else begin
         next_div   = 8'h00;
         next_count = '0;
      end
      if (tick) begin
         if (count >= period) begin // R8
            next_count = '0;
            next_wrap  = 1'b1;
         end else begin
            next_count = count + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div   <= 8'h00;
         count <= '0;
         wrap  <= 1'b0;
      end else begin
         div   <= next_div;
         count <= next_count;
         wrap  <= next_wrap;
      end
   end
endmodule // tpci_tick
`default_nettype wire

// *** tpci_timers.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - wide timer: 16-bit counter, programmable prescaler, 16-bit period.
// R2 - wide timer has five channels, each with own 16-bit compare value.
// R3 - each wide channel selects pwm output or input edge capture.
// R4 - ir mode: wide counts narrow-0 periods, output ANDed with narrow-0.
// R5 - two narrow timers: 8-bit counter, own prescaler, 8-bit period.
// R6 - each narrow timer has one 8-bit compare channel used as pwm.
// R7 - capture inputs synchronised; pulses held at least 1.5 clocks. Code needs two agreeing samples, so pulses under 2 clocks can be missed.
// R8 - counters step per tick, return to zero after reaching period.
module tpci_timers (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // wide timer control
   input  wire logic        wide_en,
   input  wire logic        ir_mode,
   input  wire logic [7:0]  wide_presc,
   input  wire logic [15:0] wide_period,
   input  wire logic [79:0] wide_cmp,
   input  wire logic [4:0]  ch_capture,
   // capture pins
   input  wire logic [4:0]  cap_in,
   // narrow timers control
   input  wire logic [1:0]  narrow_en,
   input  wire logic [15:0] narrow_presc,
   input  wire logic [15:0] narrow_period,
   input  wire logic [15:0] narrow_cmp,
   // outputs
   output logic [4:0]       wide_pwm,
   output logic [79:0]      cap_value,
   output logic [4:0]       cap_event,
   output logic [1:0]       narrow_pwm,
   output logic             ir_out,
   output logic [15:0]      wide_count
);
   // ======================================================================
   // narrow timers
   logic [7:0] ncount [2];
   logic [1:0] nwrap;
   logic [1:0] next_narrow_pwm;

   genvar n;
   generate
      for (n = 0; n < 2; n++) begin : g_narrow
         tpci_tick #(.W(tpci_pkg::NARROW_W)) u_tick ( // R5
            .mclk   (mclk),
            .rst_n  (rst_n),
            .enable (narrow_en[n]),
            .presc  (narrow_presc[8*n +: 8]),
            .period (narrow_period[8*n +: 8]),
            .count  (ncount[n]),
            .wrap   (nwrap[n])
         );
         always_comb begin
            next_narrow_pwm[n] = narrow_en[n] &&
               (ncount[n] < narrow_cmp[8*n +: 8]); // R6
         end
      end
   endgenerate

   // ======================================================================
   // wide timer; in ir mode it steps once per narrow-0 period
   logic [15:0] wcount;
   logic        wwrap;
   logic [7:0]  eff_presc;
   logic        wide_run;

   always_comb begin
      eff_presc = ir_mode ? 8'h00 : wide_presc;
      wide_run  = wide_en && (!ir_mode || nwrap[0]); // R4
   end

   // gating enable would reset the count, so ir mode holds it via hold path
   logic [15:0] hold_count;
   logic [15:0] next_hold;
   logic        hold_wrap;
   logic        next_hold_wrap;

   tpci_tick #(.W(tpci_pkg::WIDE_W)) u_wide ( // R1
      .mclk   (mclk),
      .rst_n  (rst_n),
      .enable (wide_en && !ir_mode),
      .presc  (eff_presc),
      .period (wide_period),
      .count  (wcount),
      .wrap   (wwrap)
   );

   always_comb begin
      next_hold      = hold_count;
      next_hold_wrap = 1'b0;
      if (!(wide_en && ir_mode)) begin
         next_hold = 16'h0000;
      end else if (wide_run) begin
         if (hold_count >= wide_period) begin // R8
            next_hold      = 16'h0000;
            next_hold_wrap = 1'b1;
         end else begin
            next_hold = hold_count + 16'h0001; // R4
         end
      end
   end

   logic [15:0] cur_count;
   always_comb begin
      cur_count = ir_mode ? hold_count : wcount;
   end

   // ======================================================================
   // capture synchronisers: three stages, change counts when 2 and 3 agree
   logic [4:0] s1, s2, s3, lvl;
   logic [4:0] next_lvl;
   logic [4:0] next_wide_pwm;
   logic [4:0] next_cap_event;
   logic [79:0] next_cap_value;
   logic       next_ir;

   genvar c;
   generate
      for (c = 0; c < tpci_pkg::NUM_CH; c++) begin : g_ch
         always_comb begin
            next_lvl[c] = (s2[c] == s3[c]) ? s3[c] : lvl[c]; // R7
            next_cap_event[c] = ch_capture[c] && wide_en &&
               (next_lvl[c] != lvl[c]); // R3
            next_cap_value[16*c +: 16] = next_cap_event[c] ?
               cur_count : cap_value[16*c +: 16];
            next_wide_pwm[c] = !ch_capture[c] && wide_en &&
               (cur_count < wide_cmp[16*c +: 16]); // R2
         end
      end
   endgenerate

   always_comb begin
      next_ir = next_wide_pwm[0] && next_narrow_pwm[0] && ir_mode; // R4
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1         <= 5'h00;
         s2         <= 5'h00;
         s3         <= 5'h00;
         lvl        <= 5'h00;
         hold_count <= 16'h0000;
         hold_wrap  <= 1'b0;
         wide_pwm   <= 5'h00;
         cap_event  <= 5'h00;
         cap_value  <= '0;
         narrow_pwm <= 2'h0;
         ir_out     <= 1'b0;
         wide_count <= 16'h0000;
      end else begin
         s1         <= cap_in;
         s2         <= s1;
         s3         <= s2;
         lvl        <= next_lvl;
         hold_count <= next_hold;
         hold_wrap  <= next_hold_wrap;
         wide_pwm   <= next_wide_pwm;
         cap_event  <= next_cap_event;
         cap_value  <= next_cap_value;
         narrow_pwm <= next_narrow_pwm;
         ir_out     <= next_ir;
         wide_count <= cur_count;
      end
   end

   // ======================================================================
   // checks
   property p_cap_val; // R3
      @(posedge mclk) disable iff (!rst_n)
         cap_event[2] |-> cap_value[47:32] == $past(cur_count);
   endproperty
   a_cap_val: assert property (p_cap_val) else $error("capture value wrong");

   property p_ir_and; // R4
      @(posedge mclk) disable iff (!rst_n)
         ir_out |-> narrow_pwm[0] && wide_pwm[0] && $past(ir_mode);
   endproperty
   a_ir_and: assert property (p_ir_and) else $error("ir not anded");

   property p_wrap; // R8
      @(posedge mclk) disable iff (!rst_n)
         (!ir_mode && wwrap) |-> wcount == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wide wrap not zero");

   property p_period; // R1
      @(posedge mclk) disable iff (!rst_n)
         $stable(wide_period) && !ir_mode |-> wcount <= wide_period ||
            $past(wcount) > wide_period;
   endproperty
   a_period: assert property (p_period) else $error("wide over period");

   // two agreeing samples past the first stage must move the level
   property p_sync; // R7
      @(posedge mclk) disable iff (!rst_n)
         $rose(s2[2]) ##1 s2[2] |-> ##1 lvl[2];
   endproperty
   a_sync: assert property (p_sync) else $error("capture edge missed");

   property p_npwm; // R6
      @(posedge mclk) disable iff (!rst_n)
         narrow_pwm[1] |-> $past(narrow_en[1]) &&
            ($past(ncount[1]) < $past(narrow_cmp[15:8]));
   endproperty
   a_npwm: assert property (p_npwm) else $error("narrow pwm wrong");

   property p_nper; // R5
      @(posedge mclk) disable iff (!rst_n)
         nwrap[0] |-> ncount[0] == 8'h00;
   endproperty
   a_nper: assert property (p_nper) else $error("narrow wrap not zero");

   property p_wpwm; // R2
      @(posedge mclk) disable iff (!rst_n)
         wide_pwm[4] |-> $past(wide_en) &&
            ($past(cur_count) < $past(wide_cmp[79:64]));
   endproperty
   a_wpwm: assert property (p_wpwm) else $error("wide pwm wrong");

   property p_hold_wrap; // R8
      @(posedge mclk) disable iff (!rst_n)
         hold_wrap |-> hold_count == 16'h0000;
   endproperty
   a_hold_wrap: assert property (p_hold_wrap) else $error("ir wrap not zero");
endmodule // tpci_timers
`default_nettype wire
